// >>> core/wwd_pkg.sv
// windowed watchdog: register map, field positions, reset values
// assumes a 32-bit APB slave with byte addresses and one word per register
package wwd_pkg;

    // ==========================================================
    // bus and counter widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W = 24;

    // ==========================================================
    // register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_MODE = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_TC = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_FEED = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_TV = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_WARN = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_WINDOW = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h1C;
    localparam logic [ADDR_W-1:0] ADDR_RSTFLAG = 8'h20;

    // ==========================================================
    // mode register fields
    localparam int MODE_EN = 0;
    localparam int MODE_RSTEN = 1;
    localparam int MODE_WINEN = 2;

    // ==========================================================
    // event bits, shared by status and mask
    localparam int EV_W = 4;
    localparam int EV_TIMEOUT = 0;
    localparam int EV_WARN = 1;
    localparam int EV_FEEDERR = 2;
    localparam int EV_WINERR = 3;

    // ==========================================================
    // reset values and limits
    localparam logic [CNT_W-1:0] TC_MIN = 24'h0000FF;
    localparam logic [CNT_W-1:0] TC_RST = 24'h0000FF;
    localparam logic [CNT_W-1:0] WARN_RST = 24'h000000;
    localparam logic [CNT_W-1:0] WINDOW_RST = 24'hFFFFFF;
    localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
    localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;

    // ==========================================================
    // prescaler and feed sequence
    localparam int PRE_W = 2;
    localparam logic [PRE_W-1:0] PRE_LAST = 2'h3;
    localparam logic [7:0] FEED_FIRST = 8'hAA;
    localparam logic [7:0] FEED_SECOND = 8'h55;

    // nominal watchdog clock, for software reload planning
    localparam int WATCHDOG_CLOCK_NOM_HZ = 500000;

    typedef enum logic [0:0] {
        WWD_FEED_IDLE = 1'b0,
        WWD_FEED_ARMED = 1'b1
    } wwd_feed_t;

endpackage

// >>> core/wwd_sync.sv
// three-stage synchroniser with agreement filter and rising-edge pulse
// assumes an asynchronous input and the system clock domain
`timescale 1ns/10ps
module wwd_sync (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // asynchronous level in
    input wire logic asyncIn,
    // filtered level and its rising edge
    output logic levelOut,
    output logic risePulse
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic stable_r;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= asyncIn;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // a change counts once the second and third stage agree
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            stable_r <= 1'b0;
        end else if (s2_r == s3_r) begin
            stable_r <= s3_r;
        end
    end

    assign levelOut = stable_r;
    assign risePulse = (s2_r == s3_r) && s3_r && !stable_r;
endmodule

// >>> core/wwd_watchdog.sv
// windowed watchdog core with APB register slave
// assumes rstn is the chip reset that chipResetReq drives, and porRstn the power-on reset
`timescale 1ns/10ps

// Overview of operation
// - reset the chip when no reload before time-out
// - windowed mode: feed outside window is a fault
// - warning interrupt at programmable count before time-out
// - enable sticks until reset or watchdog event
// - wrong feed sequence acts like a time-out
// - readable flag marks watchdog-caused reset
// - 24-bit counter behind an internal prescaler
// - time-out 256x4 up to 2^24x4 clock periods
// - counted from the dedicated watchdog clock
// - watchdog clock nominally 500 kHz, loosely controlled
// - keeps counting through power-down
// - enabled time-out interrupt wakes from deep-sleep
module wwd_watchdog (
    // clock and resets
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic porRstn,
    // watchdog oscillator pin
    input wire logic watchdogClock,
    // apb slave
    input wire logic [wwd_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [wwd_pkg::DATA_W-1:0] pwdata,
    output logic [wwd_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // system side
    output logic chipResetReq,
    output logic irq,
    output logic wakeReq
);
    import wwd_pkg::*;

    // ==========================================================
    // state
    logic modeEn_r;
    logic rstEn_r;
    logic winEn_r;
    logic [CNT_W-1:0] tc_r;
    logic [CNT_W-1:0] warn_r;
    logic [CNT_W-1:0] window_r;
    logic [CNT_W-1:0] cnt_r;
    logic [PRE_W-1:0] pre_r;
    wwd_feed_t feedState_r;
    logic [EV_W-1:0] stat_r;
    logic [EV_W-1:0] mask_r;
    logic chipRst_r;
    logic rstFlag_r;
    logic [DATA_W-1:0] prdata_r;
    logic pslverr_r;

    // ==========================================================
    // combinational terms
    logic wdEdge;
    logic tick;
    logic preWrap;
    logic timeoutEv;
    logic warnEv;
    logic wrEn;
    logic setup;
    logic addrOk;
    logic feedWr;
    logic firstByte;
    logic secondOk;
    logic validFeed;
    logic seqErr;
    logic winErr;
    logic goodFeed;
    logic fault;
    logic enWrite;
    logic [EV_W-1:0] ev;
    logic [DATA_W-1:0] rdMux;

    // ==========================================================
    // watchdog clock capture
    // the oscillator pin is sampled, so the bus clock must run well above it
    wwd_sync u_sync (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .asyncIn(watchdogClock),
        .levelOut(),
        .risePulse(wdEdge)
    );

    // counting ignores any low-power state of the chip
    assign tick = wdEdge && modeEn_r;
    assign preWrap = tick && (pre_r == PRE_LAST);
    assign timeoutEv = preWrap && (cnt_r == CNT_ZERO);
    assign warnEv = preWrap && (cnt_r == warn_r);

    // ==========================================================
    // apb decode
    assign setup = psel && !penable;
    assign wrEn = psel && penable && pwrite && addrOk;
    assign pready = 1'b1;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r;

    always_comb begin
        unique case (paddr)
            ADDR_MODE, ADDR_TC, ADDR_FEED, ADDR_TV, ADDR_WARN,
            ADDR_WINDOW, ADDR_STAT, ADDR_MASK, ADDR_RSTFLAG: addrOk = 1'b1;
            default: addrOk = 1'b0;
        endcase
    end

    always_comb begin
        rdMux = '0;
        unique case (paddr)
            ADDR_MODE: begin
                rdMux[MODE_EN] = modeEn_r;
                rdMux[MODE_RSTEN] = rstEn_r;
                rdMux[MODE_WINEN] = winEn_r;
            end
            ADDR_TC: rdMux[CNT_W-1:0] = tc_r;
            ADDR_TV: rdMux[CNT_W-1:0] = cnt_r;
            ADDR_WARN: rdMux[CNT_W-1:0] = warn_r;
            ADDR_WINDOW: rdMux[CNT_W-1:0] = window_r;
            ADDR_STAT: rdMux[EV_W-1:0] = stat_r;
            ADDR_MASK: rdMux[EV_W-1:0] = mask_r;
            ADDR_RSTFLAG: rdMux[0] = rstFlag_r;
            default: rdMux = '0;
        endcase
    end

    // read data and error are captured in setup and stand through access
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            prdata_r <= '0;
            pslverr_r <= 1'b0;
        end else if (setup) begin
            prdata_r <= rdMux;
            pslverr_r <= !addrOk;
        end
    end

    // ==========================================================
    // feed sequence
    assign feedWr = wrEn && (paddr == ADDR_FEED);
    assign firstByte = feedWr && (pwdata[7:0] == FEED_FIRST);
    assign secondOk = feedWr && (pwdata[7:0] == FEED_SECOND) && (feedState_r == WWD_FEED_ARMED);
    assign validFeed = secondOk;

    // any other write to a mapped register between the two feed words breaks the sequence
    assign seqErr = modeEn_r && (
        ((feedState_r == WWD_FEED_ARMED) && wrEn && !secondOk) ||
        ((feedState_r == WWD_FEED_IDLE) && feedWr && !firstByte));

    // feeding above the window value is too early
    assign winErr = validFeed && modeEn_r && winEn_r && (cnt_r > window_r);
    assign goodFeed = validFeed && !winErr;
    assign fault = timeoutEv || seqErr || winErr;
    assign enWrite = wrEn && (paddr == ADDR_MODE) && pwdata[MODE_EN] && !modeEn_r;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            feedState_r <= WWD_FEED_IDLE;
        end else if (wrEn) begin
            if (feedState_r == WWD_FEED_IDLE && firstByte) begin
                feedState_r <= WWD_FEED_ARMED;
            end else begin
                feedState_r <= WWD_FEED_IDLE;
            end
        end
    end

    // ==========================================================
    // mode register
    // enable and reset action can only be set; a fault drops the enable
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            modeEn_r <= 1'b0;
            rstEn_r <= 1'b0;
            winEn_r <= 1'b0;
        end else begin
            if (fault) begin
                modeEn_r <= 1'b0;
            end else if (wrEn && paddr == ADDR_MODE && pwdata[MODE_EN]) begin
                modeEn_r <= 1'b1;
            end
            if (wrEn && paddr == ADDR_MODE) begin
                rstEn_r <= rstEn_r || pwdata[MODE_RSTEN];
                winEn_r <= pwdata[MODE_WINEN];
            end
        end
    end

    // ==========================================================
    // time-out, warning and window values
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tc_r <= TC_RST;
        end else if (wrEn && paddr == ADDR_TC) begin
            if (pwdata[CNT_W-1:0] < TC_MIN) begin
                tc_r <= TC_MIN;
            end else begin
                tc_r <= pwdata[CNT_W-1:0];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            warn_r <= WARN_RST;
            window_r <= WINDOW_RST;
        end else if (wrEn) begin
            if (paddr == ADDR_WARN) begin
                warn_r <= pwdata[CNT_W-1:0];
            end
            if (paddr == ADDR_WINDOW) begin
                window_r <= pwdata[CNT_W-1:0];
            end
        end
    end

    // ==========================================================
    // prescaler and down counter
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pre_r <= '0;
            cnt_r <= TC_RST;
        end else if (enWrite || goodFeed) begin
            pre_r <= '0;
            cnt_r <= tc_r;
        end else if (tick) begin
            pre_r <= pre_r + 1'b1;
            if (preWrap && cnt_r != CNT_ZERO) begin
                cnt_r <= cnt_r - CNT_ONE;
            end
        end
    end

    // ==========================================================
    // interrupt status and mask
    always_comb begin
        ev = '0;
        ev[EV_TIMEOUT] = timeoutEv;
        ev[EV_WARN] = warnEv;
        ev[EV_FEEDERR] = seqErr;
        ev[EV_WINERR] = winErr;
    end

    // write one to clear; a new event in the same cycle wins
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            stat_r <= '0;
        end else if (wrEn && paddr == ADDR_STAT) begin
            stat_r <= (stat_r & ~pwdata[EV_W-1:0]) | ev;
        end else begin
            stat_r <= stat_r | ev;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mask_r <= '0;
        end else if (wrEn && paddr == ADDR_MASK) begin
            mask_r <= pwdata[EV_W-1:0];
        end
    end

    assign irq = |(stat_r & mask_r);
    assign wakeReq = stat_r[EV_TIMEOUT] && mask_r[EV_TIMEOUT];

    // ==========================================================
    // chip reset request and reset-cause flag
    // request holds until the chip reset it causes comes back on rstn
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            chipRst_r <= 1'b0;
        end else if (fault && rstEn_r) begin
            chipRst_r <= 1'b1;
        end
    end

    assign chipResetReq = chipRst_r;

    // flag lives on power-on reset only, so it survives the chip reset
    always_ff @(posedge sys_clk or negedge porRstn) begin
        if (!porRstn) begin
            rstFlag_r <= 1'b0;
        end else if (chipRst_r) begin
            rstFlag_r <= 1'b1;
        end else if (wrEn && paddr == ADDR_RSTFLAG && pwdata[0]) begin
            rstFlag_r <= 1'b0;
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    property p_timeout_reset;
        timeoutEv && rstEn_r |=> chipResetReq;
    endproperty
    a_timeout_reset: assert property (p_timeout_reset) else $error("time-out did not request reset");

    property p_window_fault;
        validFeed && modeEn_r && winEn_r && (cnt_r > window_r) |=> stat_r[EV_WINERR] && !modeEn_r;
    endproperty
    a_window_fault: assert property (p_window_fault) else $error("early feed not flagged");

    property p_warn;
        warnEv |=> stat_r[EV_WARN] && (!mask_r[EV_WARN] || irq);
    endproperty
    a_warn: assert property (p_warn) else $error("warning not raised");

    property p_en_locked;
        modeEn_r && !fault |=> modeEn_r;
    endproperty
    a_en_locked: assert property (p_en_locked) else $error("enable dropped without fault");

    // armed may last any number of idle cycles before the next write
    sequence s_armed;
        modeEn_r && (feedState_r == WWD_FEED_ARMED);
    endsequence
    sequence s_bad_second;
        wrEn && !(feedWr && pwdata[7:0] == FEED_SECOND);
    endsequence
    property p_seq_fault;
        s_armed ##0 s_bad_second |=> stat_r[EV_FEEDERR] && !modeEn_r;
    endproperty
    a_seq_fault: assert property (p_seq_fault) else $error("bad feed sequence missed");

    property p_rst_flag;
        chipRst_r |=> rstFlag_r;
    endproperty
    a_rst_flag: assert property (p_rst_flag) else $error("reset cause flag not set");

    property p_tc_range;
        tc_r >= TC_MIN;
    endproperty
    a_tc_range: assert property (p_tc_range) else $error("time-out constant below minimum");

    property p_hold;
        !tick && !enWrite && !goodFeed |=> $stable(cnt_r);
    endproperty
    a_hold: assert property (p_hold) else $error("counter moved without a tick");

    property p_feed_reload;
        goodFeed |=> (cnt_r == tc_r) && (pre_r == '0);
    endproperty
    a_feed_reload: assert property (p_feed_reload) else $error("feed did not reload");

endmodule

// >>> tb/testbench.sv
// self-checking bench for the windowed watchdog, APB master tasks and scenarios
// assumes wwd_pkg and wwd_watchdog are compiled first; no partner model
`timescale 1ns/10ps
module testbench;
    import wwd_pkg::*;

    // ==========================================================
    // clocks, resets and bus
    logic sysClk = 1'b0;
    logic rstn = 1'b0;
    logic porRstn = 1'b0;
    logic watchdogClock = 1'b0;
    logic [1:0] wdDiv = 2'h0;
    logic [ADDR_W-1:0] paddr = '0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic chipResetReq;
    logic irq;
    logic wakeReq;
    logic [DATA_W-1:0] rd;
    logic err;
    int failures = 0;
    int checked = 0;
    int n;

    wwd_watchdog dut (.sys_clk(sysClk), .rstn(rstn), .porRstn(porRstn), .watchdogClock(watchdogClock),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .chipResetReq(chipResetReq),
        .irq(irq), .wakeReq(wakeReq));

    initial begin
        forever #4 sysClk = ~sysClk;
    end

    // watchdog clock at one eighth of the system clock, well under sys_clk/4
    always @(posedge sysClk) begin
        wdDiv <= wdDiv + 2'h1;
        if (wdDiv == 2'h3) begin
            watchdogClock <= ~watchdogClock;
        end
    end

    // ==========================================================
    // shared tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge sysClk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sysClk);
        penable <= 1'b1;
        @(posedge sysClk);
        while (pready !== 1'b1) @(posedge sysClk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // waits on irq, or on chipResetReq when useIrq is low
    task automatic wait_high(input bit useIrq, input int limit);
        n = 0;
        while ((useIrq ? irq : chipResetReq) !== 1'b1 && n < limit) begin
            @(posedge sysClk);
            n++;
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ==========================================================
    // scenarios
    task automatic t_regs;
        logic [ADDR_W-1:0] addrs [7] = '{ADDR_MODE, ADDR_TC, ADDR_WARN, ADDR_WINDOW, ADDR_STAT, ADDR_MASK, ADDR_FEED};
        logic [31:0] vals [7] = '{32'h0, 32'h0000_00FF, 32'h0, 32'h00FF_FFFF, 32'h0, 32'h0, 32'h0};
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, addrs[i], 32'h0);
            check("reset value", rd, vals[i]);
        end
        apb(1'b0, 8'h24, 32'h0);
        check("unmapped data", rd, 32'h0);
        check("unmapped error", {31'h0, err}, 32'h1);
        check("ready", {31'h0, pready}, 32'h1);
        apb(1'b1, ADDR_TC, 32'h0000_0010);
        apb(1'b0, ADDR_TC, 32'h0);
        check("tc clamp", rd, 32'h0000_00FF);
        apb(1'b1, ADDR_TC, 32'hFFFF_FFFF);
        apb(1'b0, ADDR_TC, 32'h0);
        check("tc full width", rd, 32'h00FF_FFFF);
        apb(1'b1, ADDR_TC, 32'h0000_00FF);
        $display("test regs done");
    endtask

    task automatic t_lock_feed;
        apb(1'b1, ADDR_MASK, 32'h0000_0004);
        apb(1'b1, ADDR_MODE, 32'h0000_0001);
        apb(1'b1, ADDR_MODE, 32'h0000_0000);
        apb(1'b0, ADDR_MODE, 32'h0);
        check("enable locked", rd & 32'h1, 32'h1);
        repeat (200) @(posedge sysClk);
        apb(1'b0, ADDR_TV, 32'h0);
        check("counting down", {31'h0, rd < 32'hFF && rd > 32'hF0}, 32'h1);
        apb(1'b1, ADDR_FEED, 32'h0000_00AA);
        apb(1'b1, ADDR_FEED, 32'h0000_0055);
        apb(1'b0, ADDR_TV, 32'h0);
        check("feed reload", {31'h0, rd >= 32'hFE}, 32'h1);
        apb(1'b1, ADDR_FEED, 32'h0000_00AA);
        apb(1'b1, ADDR_WARN, 32'h0);
        repeat (2) @(posedge sysClk);
        check("bad sequence irq", {31'h0, irq}, 32'h1);
        apb(1'b0, ADDR_STAT, 32'h0);
        check("bad sequence status", rd, 32'h4);
        apb(1'b0, ADDR_MODE, 32'h0);
        check("fault clears enable", rd & 32'h1, 32'h0);
        apb(1'b1, ADDR_STAT, 32'h0000_0004);
        @(posedge sysClk);
        check("irq cleared", {31'h0, irq}, 32'h0);
        $display("test lock and feed done");
    endtask

    task automatic t_window;
        apb(1'b1, ADDR_MASK, 32'h0000_0008);
        apb(1'b1, ADDR_WINDOW, 32'h0000_0010);
        apb(1'b1, ADDR_MODE, 32'h0000_0005);
        apb(1'b1, ADDR_FEED, 32'h0000_00AA);
        apb(1'b1, ADDR_FEED, 32'h0000_0055);
        repeat (2) @(posedge sysClk);
        check("early feed irq", {31'h0, irq}, 32'h1);
        apb(1'b0, ADDR_STAT, 32'h0);
        check("window status", rd, 32'h8);
        apb(1'b1, ADDR_STAT, 32'h0000_000F);
        apb(1'b1, ADDR_MODE, 32'h0);
        apb(1'b0, ADDR_MODE, 32'h0);
        check("window mode off", rd, 32'h0);
        apb(1'b1, ADDR_WINDOW, 32'h00FF_FFFF);
        $display("test window done");
    endtask

    task automatic t_warn_timeout;
        int total;
        apb(1'b1, ADDR_MASK, 32'h0000_0003);
        apb(1'b1, ADDR_WARN, 32'h0000_0080);
        apb(1'b1, ADDR_MODE, 32'h0000_0001);
        wait_high(1'b1, 9000);
        total = n;
        check("warning time", {31'h0, n >= 4040 && n <= 4120}, 32'h1);
        check("warning only", {31'h0, wakeReq}, 32'h0);
        apb(1'b1, ADDR_STAT, 32'h0000_0002);
        // let the clear land before watching irq again
        @(posedge sysClk);
        wait_high(1'b1, 9000);
        total = total + n + 4;
        check("timeout time", {31'h0, total >= 8170 && total <= 8240}, 32'h1);
        check("wake request", {31'h0, wakeReq}, 32'h1);
        apb(1'b0, ADDR_STAT, 32'h0);
        check("timeout status", rd, 32'h1);
        check("no chip reset", {31'h0, chipResetReq}, 32'h0);
        apb(1'b1, ADDR_STAT, 32'h0000_000F);
        $display("test warning and timeout done");
    endtask

    task automatic t_reset_flag;
        apb(1'b1, ADDR_MASK, 32'h0);
        apb(1'b1, ADDR_MODE, 32'h0000_0003);
        wait_high(1'b0, 9000);
        check("chip reset on timeout", {31'h0, n >= 8150 && n <= 8240}, 32'h1);
        repeat (20) @(posedge sysClk);
        check("reset held", {31'h0, chipResetReq}, 32'h1);
        check("masked irq", {31'h0, irq}, 32'h0);
        @(posedge sysClk);
        rstn <= 1'b0;
        repeat (3) @(posedge sysClk);
        rstn <= 1'b1;
        @(posedge sysClk);
        check("reset released", {31'h0, chipResetReq}, 32'h0);
        apb(1'b0, ADDR_RSTFLAG, 32'h0);
        check("watchdog reset flag", rd, 32'h1);
        apb(1'b0, ADDR_MODE, 32'h0);
        check("enable after reset", rd, 32'h0);
        apb(1'b1, ADDR_RSTFLAG, 32'h0000_0001);
        apb(1'b0, ADDR_RSTFLAG, 32'h0);
        check("flag cleared", rd, 32'h0);
        $display("test reset flag done");
    endtask

    // ==========================================================
    // main sequence and hang guard
    initial begin
        repeat (10) @(posedge sysClk);
        rstn <= 1'b1;
        porRstn <= 1'b1;
        t_regs();
        t_lock_feed();
        t_window();
        t_warn_timeout();
        t_reset_flag();
        wrap_up();
    end

    initial begin
        repeat (60000) @(posedge sysClk);
        failures++;
        $display("wrong value watchdog expected finish seen hang");
        wrap_up();
    end
endmodule
